// ---- rtl/inband_loopback_code_control.sv ----
// Inband loopback code logic for eight line channels: code detection,
// status, maskable interrupt flags, code generators, AHB-Lite registers.
// Assumes line bit strobes are synchronous to clock and one cycle wide.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
// Notes on behaviour
// - deactivation code taken from upper register bits
// - one deactivation code shared by all channels
// - status one after activation, zero after deactivation
// - mask bit one allows channel interrupt
// - flag set on status change when enabled
// - reading status register clears all flags
// - select zero sends activation, one deactivation
// - generator runs only while enable bit set
// - deactivation length field picks five to eight
// - activation length field picks five to eight
// - detector enable bit turns detection on
// - automatic loopback follows detected codes
module inband_loopback_code_control #(
	parameter int CHANNELS = 8,                                // Line channels
	parameter int REPEATS  = loopback_pkg::MATCH_REPEATS       // Code periods to confirm
) (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	input  wire loopback_pkg::line_rx_t   line_rx,
	input  wire loopback_pkg::line_tx_t   line_tx,
	output logic      [7:0]               tx_out,
	output logic      [7:0]               loop_active,
	output logic                          irq
);
	import loopback_pkg::*;

	// ==========================================================
	// Bus slave
	// ==========================================================
	logic        wr_pend_reg;                                  // Write data phase pending
	logic [7:0]  wr_idx_reg;                                   // Index of the pending write
	logic [31:0] rdata_reg;                                    // Read data for the data phase
	logic        rd_status_reg;                                // Status read just taken
	wire         take  = hsel & hready & htrans[1];            // NONSEQ or SEQ address phase
	wire         idx_ok = (haddr[1:0] == 2'h0) & (haddr[31:10] == 22'h000000);   // No aliases above the map
	wire  [7:0]  idx   = haddr[9:2];
	wire         rd_take = take & ~hwrite & idx_ok;
	wire  [7:0]  wbyte = hwdata[7:0];

	// Registers
	loop_config_t       cfg_reg;
	logic [7:0]         act_code_reg;
	logic [7:0]         deact_code_reg;                        // Single copy for all channels
	logic [7:0]         loop_status_reg;
	logic [7:0]         loop_irq_mask_reg;
	logic [7:0]         loop_irq_flag_reg;
	logic [7:0]         gen_select_reg;
	logic [7:0]         gen_enable_reg;

	wire wr_cfg   = wr_pend_reg & (wr_idx_reg == IDX_LOOP_CONFIG);
	wire wr_act   = wr_pend_reg & (wr_idx_reg == IDX_ACT_CODE);
	wire wr_deact = wr_pend_reg & (wr_idx_reg == IDX_DEACT_CODE);
	wire wr_mask  = wr_pend_reg & (wr_idx_reg == IDX_IRQ_MASK);
	wire wr_gsel  = wr_pend_reg & (wr_idx_reg == IDX_GEN_SELECT);
	wire wr_gen   = wr_pend_reg & (wr_idx_reg == IDX_GEN_ENABLE);

	// Read mux as an else-if chain; unmapped words read zero
	logic [7:0] rd_byte;
	always_comb begin
		if (idx == IDX_LOOP_CONFIG)      rd_byte = {2'h0, cfg_reg};
		else if (idx == IDX_ACT_CODE)    rd_byte = act_code_reg;
		else if (idx == IDX_DEACT_CODE)  rd_byte = deact_code_reg;
		else if (idx == IDX_LOOP_STATUS) rd_byte = loop_status_reg;
		else if (idx == IDX_IRQ_MASK)    rd_byte = loop_irq_mask_reg;
		else if (idx == IDX_IRQ_FLAG)    rd_byte = loop_irq_flag_reg;
		else if (idx == IDX_GEN_SELECT)  rd_byte = gen_select_reg;
		else if (idx == IDX_GEN_ENABLE)  rd_byte = gen_enable_reg;
		else if (idx == IDX_LOOP_ACTIVE) rd_byte = loop_active;
		else                             rd_byte = RESET_BYTE;
	end

	// Zero wait states: capture address, answer in the next cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_pend_reg   <= 1'b0;
			wr_idx_reg    <= RESET_BYTE;
			rdata_reg     <= 32'h00000000;
			rd_status_reg <= 1'b0;
		end else begin
			wr_pend_reg   <= take & hwrite & idx_ok;
			wr_idx_reg    <= idx;
			rdata_reg     <= rd_take ? {24'h000000, rd_byte} : 32'h00000000;
			rd_status_reg <= rd_take & (idx == IDX_LOOP_STATUS);
		end
	end
	assign hrdata    = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Writable registers; reserved config bits are dropped
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_reg           <= '0;
			act_code_reg      <= RESET_BYTE;
			deact_code_reg    <= RESET_BYTE;
			loop_irq_mask_reg <= RESET_BYTE;
			gen_select_reg    <= RESET_BYTE;
			gen_enable_reg    <= RESET_BYTE;
		end else begin
			if (wr_cfg)   cfg_reg           <= loop_config_t'(wbyte[5:0]);
			if (wr_act)   act_code_reg      <= wbyte;
			if (wr_deact) deact_code_reg    <= wbyte;        // Replication is software's job
			if (wr_mask)  loop_irq_mask_reg <= wbyte;
			if (wr_gsel)  gen_select_reg    <= wbyte;
			if (wr_gen)   gen_enable_reg    <= wbyte;
		end
	end

	// ==========================================================
	// Code length selection
	// ==========================================================
	// Length as a count of bits; code occupies the upper bits
	function automatic logic [3:0] code_len(input logic [1:0] sel);
		logic [3:0] n;
		n = 4'h5 + {2'h0, sel};                               // 00=5 .. 11=8
		return n;
	endfunction
	wire [3:0] act_len   = code_len(cfg_reg.act_length);
	wire [3:0] deact_len = code_len(cfg_reg.deact_length);
	wire       det_on    = cfg_reg.det_enable;

	// ==========================================================
	// Per-channel detector and generator
	// ==========================================================
	logic [7:0] status_next;
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			logic [2:0] phase_reg;                             // Bits into the current activation period
			logic [2:0] d_phase_reg;                           // Bits into the current deactivation period
			logic [5:0] act_run_reg;                           // Matched bits for activation
			logic [5:0] deact_run_reg;                         // Matched bits for deactivation
			logic [2:0] gen_pos_reg;                            // Generator bit position
			wire        rv = line_rx.rx_valid[ch];
			wire        rb = line_rx.rx_bit[ch];
			// Each received bit must equal the register bit for its place in the
			// period; every period follows the upper register bits in order
			wire [3:0]  a_idx = 4'h7 - {1'b0, phase_reg};
			wire [3:0]  d_idx = 4'h7 - {1'b0, d_phase_reg};
			wire        act_bit_ok   = (rb == act_code_reg[a_idx[2:0]]);
			wire        deact_bit_ok = (rb == deact_code_reg[d_idx[2:0]]);
			wire [5:0]  need_a = 6'(act_len) * 6'(REPEATS);
			wire [5:0]  need_d = 6'(deact_len) * 6'(REPEATS);
			wire        act_seen   = det_on & (act_run_reg >= need_a);
			wire        deact_seen = det_on & (deact_run_reg >= need_d);
			// Each code keeps its own phase counter, so the two lengths may
			// differ; both restart when the detector is switched on, and the
			// far end must begin a code period there to be recognised
			wire [2:0]  last_a = 3'(act_len - 4'h1);
			wire [2:0]  last_d = 3'(deact_len - 4'h1);
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					phase_reg     <= 3'h0;
					d_phase_reg   <= 3'h0;
					act_run_reg   <= 6'h00;
					deact_run_reg <= 6'h00;
				end else if (!det_on) begin
					phase_reg     <= 3'h0;
					d_phase_reg   <= 3'h0;
					act_run_reg   <= 6'h00;
					deact_run_reg <= 6'h00;
				end else if (rv) begin
					phase_reg     <= (phase_reg == last_a) ? 3'h0 : phase_reg + 3'h1;
					d_phase_reg   <= (d_phase_reg == last_d) ? 3'h0 : d_phase_reg + 3'h1;
					act_run_reg   <= act_bit_ok ? (act_run_reg == 6'h3F ? act_run_reg : act_run_reg + 6'h01)
					                            : 6'h00;
					deact_run_reg <= deact_bit_ok ? (deact_run_reg == 6'h3F ? deact_run_reg
					                                 : deact_run_reg + 6'h01) : 6'h00;
				end
			end
			// Status: set on activation, cleared on deactivation
			always_comb begin
				if (deact_seen)    status_next[ch] = 1'b0;
				else if (act_seen) status_next[ch] = 1'b1;
				else               status_next[ch] = loop_status_reg[ch];
			end
			// Generator: repeats the chosen code while enabled
			wire [1:0] g_sel  = gen_select_reg[ch] ? cfg_reg.deact_length : cfg_reg.act_length;
			wire [7:0] g_code = gen_select_reg[ch] ? deact_code_reg : act_code_reg;
			wire [2:0] g_last = 3'(code_len(g_sel) - 4'h1);
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					gen_pos_reg <= 3'h0;
					tx_out[ch]  <= 1'b0;
				end else if (!gen_enable_reg[ch]) begin
					gen_pos_reg <= 3'h0;
					tx_out[ch]  <= line_tx.tx_ready[ch] ? line_tx.tx_data[ch] : tx_out[ch];
				end else if (line_tx.tx_ready[ch]) begin
					gen_pos_reg <= (gen_pos_reg >= g_last) ? 3'h0 : gen_pos_reg + 3'h1;
					tx_out[ch]  <= g_code[3'h7 - gen_pos_reg];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Status, flags, interrupt and automatic loopback
	// ==========================================================
	wire [7:0] status_change = status_next ^ loop_status_reg;
	wire [7:0] flag_set = det_on ? (status_change & loop_irq_mask_reg) : 8'h00;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			loop_status_reg   <= RESET_BYTE;
			loop_irq_flag_reg <= RESET_BYTE;
			loop_active       <= RESET_BYTE;
		end else begin
			loop_status_reg   <= status_next;
			// A new change in the clearing cycle is kept
			loop_irq_flag_reg <= (rd_status_reg ? 8'h00 : loop_irq_flag_reg) | flag_set;
			loop_active       <= cfg_reg.auto_loop ? status_next : 8'h00;
		end
	end
	assign irq = |(loop_irq_flag_reg & loop_irq_mask_reg);

	// ==========================================================
	// Checks
	// ==========================================================
	// Checks sample design signals, plus hwdata in the mask check, line_tx in the pass-through and first-bit checks, bus inputs in the status read check
	property p_status_clears_flags;
		@(posedge clock) disable iff (rst)
		rd_status_reg |=> ((loop_irq_flag_reg & ~$past(flag_set)) == 8'h00);
	endproperty
	a_status_clears_flags: assert property (p_status_clears_flags) else $error("flags not cleared by status read");
	property p_flag_needs_enable;
		@(posedge clock) disable iff (rst)
		(!det_on && !rd_status_reg) |=> (loop_irq_flag_reg == $past(loop_irq_flag_reg));
	endproperty
	a_flag_needs_enable: assert property (p_flag_needs_enable) else $error("flag set while detector off");
	property p_change_sets_flag;
		@(posedge clock) disable iff (rst)
		(det_on && |(status_change & loop_irq_mask_reg)) |=> |loop_irq_flag_reg;
	endproperty
	a_change_sets_flag: assert property (p_change_sets_flag) else $error("status change lost");
	property p_irq_masked;
		@(posedge clock) disable iff (rst)
		(loop_irq_mask_reg == 8'h00) |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
	property p_auto_off;
		@(posedge clock) disable iff (rst)
		!cfg_reg.auto_loop |=> (loop_active == 8'h00);
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("loopback without auto enable");
	property p_auto_follows;
		@(posedge clock) disable iff (rst)
		cfg_reg.auto_loop |=> (loop_active == loop_status_reg);
	endproperty
	a_auto_follows: assert property (p_auto_follows) else $error("loopback not following status");
	property p_gen_off_passes;
		@(posedge clock) disable iff (rst)
		(!gen_enable_reg[0] && line_tx.tx_ready[0]) |=> (tx_out[0] == $past(line_tx.tx_data[0]));
	endproperty
	a_gen_off_passes: assert property (p_gen_off_passes) else $error("data not passed when off");
	property p_status_stable_off;
		@(posedge clock) disable iff (rst)
		!det_on |=> $stable(loop_status_reg);
	endproperty
	a_status_stable_off: assert property (p_status_stable_off) else $error("status moved while off");
	// No flag bit may rise on a channel whose mask was clear
	property p_flag_needs_mask;
		@(posedge clock) disable iff (rst)
		!rd_status_reg |=> ((loop_irq_flag_reg & ~$past(loop_irq_flag_reg) & ~$past(loop_irq_mask_reg)) == 8'h00);
	endproperty
	a_flag_needs_mask: assert property (p_flag_needs_mask) else $error("flag set on masked channel");
	// A status read returns the status held at its address phase
	property p_status_read_data;
		@(posedge clock) disable iff (rst)
		(rd_take && (idx == IDX_LOOP_STATUS)) |=> (hrdata == {24'h000000, $past(loop_status_reg)});
	endproperty
	a_status_read_data: assert property (p_status_read_data) else $error("status read data wrong");
	// A mask write lands at the end of its data phase
	property p_mask_write_lands;
		@(posedge clock) disable iff (rst)
		wr_mask |=> (loop_irq_mask_reg == $past(wbyte));
	endproperty
	a_mask_write_lands: assert property (p_mask_write_lands) else $error("mask write lost");
	// Channel 1's deactivation generator opens each period with the top code bit
	property p_gen_first_bit;
		@(posedge clock) disable iff (rst)
		(gen_enable_reg[1] && gen_select_reg[1] && line_tx.tx_ready[1] && (g_chan[1].gen_pos_reg == 3'h0))
			|=> (tx_out[1] == $past(deact_code_reg[CODE_BITS - 1]));
	endproperty
	a_gen_first_bit: assert property (p_gen_first_bit) else $error("generator first bit wrong");
endmodule

// ---- rtl/loopback_pkg.sv ----
// Package for the inband loopback code block: register map, field layout,
// reset values and structs shared by the design.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
package loopback_pkg;
	// ==========================================================
	// Register indices and byte addresses
	// ==========================================================
	localparam logic [7:0]  IDX_LOOP_CONFIG  = 8'h08;          // Global configuration
	localparam logic [7:0]  IDX_ACT_CODE     = 8'h09;          // Activation code
	localparam logic [7:0]  IDX_DEACT_CODE   = 8'h0A;          // Deactivation code
	localparam logic [7:0]  IDX_LOOP_STATUS  = 8'h0B;          // Receive status
	localparam logic [7:0]  IDX_IRQ_MASK     = 8'h0C;          // Interrupt mask
	localparam logic [7:0]  IDX_IRQ_FLAG     = 8'h0D;          // Interrupt flags
	localparam logic [7:0]  IDX_GEN_SELECT   = 8'h0E;          // Generator select
	localparam logic [7:0]  IDX_GEN_ENABLE   = 8'h0F;          // Generator enable
	localparam logic [7:0]  IDX_LOOP_ACTIVE  = 8'h10;          // Automatic loopback state
	localparam int          ADDR_SHIFT       = 2;              // Byte address is four times the index
	// ==========================================================
	// Configuration field positions
	// ==========================================================
	localparam int          CFG_DEACT_LEN_LO = 0;              // Deactivation length field
	localparam int          CFG_ACT_LEN_LO   = 2;              // Activation length field
	localparam int          CFG_AUTO_LOOP    = 4;              // Automatic loopback enable
	localparam int          CFG_DET_ENABLE   = 5;              // Detector enable
	localparam logic [7:0]  CFG_WRITE_MASK   = 8'h3F;          // Bits 7..6 are reserved
	localparam logic [7:0]  RESET_BYTE       = 8'h00;          // Every register resets to zero
	// ==========================================================
	// Code lengths and detection timing
	// ==========================================================
	localparam logic [1:0]  LEN_5            = 2'h0;
	localparam logic [1:0]  LEN_6            = 2'h1;
	localparam logic [1:0]  LEN_7            = 2'h2;
	localparam logic [1:0]  LEN_8            = 2'h3;
	localparam int          CODE_BITS        = 8;              // Register width of a code
	localparam int          MATCH_REPEATS    = 4;              // Whole code periods to confirm
	// ==========================================================
	// Carriers
	// ==========================================================
	typedef struct packed {
		logic       det_enable;
		logic       auto_loop;
		logic [1:0] act_length;
		logic [1:0] deact_length;
	} loop_config_t;
	typedef struct packed {
		logic [7:0] rx_valid;                                  // One-cycle bit strobe per channel
		logic [7:0] rx_bit;                                    // Received bit per channel
	} line_rx_t;
	typedef struct packed {
		logic [7:0] tx_ready;                                  // Transmitter wants a bit
		logic [7:0] tx_data;                                   // Normal transmit data
	} line_tx_t;
endpackage

// ---- tb/inband_loopback_code_control_bench.sv ----
// Bench: registers, detection rows, interrupts, generators.
// Assumes line_far_end on the line side and one AHB-Lite slave.
`timescale 1ns/10ps
module inband_loopback_code_control_bench;
	import loopback_pkg::*;
	// ==========
	// Signals and detection rows
	logic		clock, hreadyout, hresp, busy, irq;
	logic		rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, start = 1'b0, tx_run = 1'b0;
	logic [1:0]	htrans = 2'h0, len_sel = 2'h0;
	logic [3:0]	gap = 4'h2;
	logic [7:0]	use_deact = 8'h00, acode = 8'h00, dcode = 8'h00, tx_out, loop_active;
	logic [31:0]	haddr = 32'h0, hwdata = 32'h0, hrdata;
	line_rx_t	line_rx;
	line_tx_t	line_tx;
	int		err_total, n_tests, cycles;
	typedef struct packed {
		logic [1:0] len;
		logic auto_on;
		logic [3:0] gap;	// Slow rows stress bit spacing
		logic [7:0] mask;	// Also the flags expected
		logic [7:0] active;	// Loop state expected
	} row_t;
	row_t rows [4] = '{'{LEN_5, 1'b1, 4'h2, 8'h0F, 8'hFF}, '{LEN_6, 1'b0, 4'h5, 8'hF0, 8'h00},
		'{LEN_7, 1'b1, 4'h1, 8'hFF, 8'hFF}, '{LEN_8, 1'b0, 4'h3, 8'h81, 8'h00}};
	logic [7:0]	regs [9] = '{IDX_LOOP_CONFIG, IDX_ACT_CODE, IDX_DEACT_CODE, IDX_LOOP_STATUS,
		IDX_IRQ_MASK, IDX_IRQ_FLAG, IDX_GEN_SELECT, IDX_GEN_ENABLE, IDX_LOOP_ACTIVE};
	inband_loopback_code_control #(.REPEATS(2)) i_dut (.clock(clock), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .line_rx(line_rx),
		.line_tx(line_tx), .tx_out(tx_out), .loop_active(loop_active), .irq(irq));
	line_far_end i_far (.clock(clock), .rst(rst), .start(start), .len_sel(len_sel), .act_code(acode),
		.deact_code(dcode), .use_deact(use_deact), .gap(gap), .tx_run(tx_run), .busy(busy),
		.line_rx(line_rx), .line_tx(line_tx));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Hang guard: the run needs about a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			results();
		end
	end
	// ==========
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One word transfer; read data taken at the edge ending the data phase
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] r);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, idx, d, r);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] r;
		bus(1'b0, idx, 8'h00, r);
		check(r, {24'h0, exp});
	endtask
	// Short codes carry their top bits again in the unused low bits
	function automatic logic [7:0] rep(input logic [7:0] top, input logic [1:0] ls);
		logic [7:0] r;
		r = top;
		for (int i = 2 - ls; i >= 0; i--)
			r[i] = r[i + 5 + ls];
		return r;
	endfunction
	// Codes, mask, then config with the detector restarted
	task automatic setup(input logic [1:0] len, input logic det, input logic auto_on, input logic [7:0] m);
		acode <= rep(8'hC0, len);
		dcode <= rep(8'hE0, len);
		len_sel <= len;
		wr(IDX_LOOP_CONFIG, 8'h00);
		wr(IDX_ACT_CODE, rep(8'hC0, len));
		wr(IDX_DEACT_CODE, rep(8'hE0, len));
		wr(IDX_IRQ_MASK, m);
		wr(IDX_LOOP_CONFIG, {2'b00, det, auto_on, len, len});
	endtask
	task automatic send(input logic [7:0] which);
		@(posedge clock);
		use_deact <= which;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		do @(posedge clock); while (busy === 1'b1);
		repeat (4) @(posedge clock);
	endtask
	// Enabled channels repeat their 7-bit code, others pass data
	task automatic tx_check(input logic [7:0] en, input logic [7:0] sel, input int n);
		logic [7:0] exp;
		int i;
		i = 0;
		while (i < n) begin
			@(posedge clock);
			if (line_tx.tx_ready[0] === 1'b1) begin
				exp = line_tx.tx_data;
				for (int j = 0; j < 8; j++)
					if (en[j]) exp[j] = sel[j] ? dcode[7 - i % 7] : acode[7 - i % 7];
				#1;
				check(32'(tx_out), 32'(exp));
				i++;
			end
		end
	endtask
	// ==========
	// Main sequence
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		foreach (regs[i])
			rd(regs[i], RESET_BYTE);
		check(32'({hreadyout, irq, hresp, loop_active, tx_out}), 32'h00040000);
		wr(IDX_DEACT_CODE, 8'hA5);
		rd(IDX_DEACT_CODE, 8'hA5);
		wr(IDX_IRQ_FLAG, 8'hFF);
		rd(IDX_IRQ_FLAG, 8'h00);
		wr(8'h20, 8'hFF);
		rd(8'h20, 8'h00);
		// Detector off: a clean activation code changes nothing
		setup(LEN_6, 1'b0, 1'b1, 8'hFF);
		send(8'h00);
		rd(IDX_LOOP_STATUS, 8'h00);
		rd(IDX_IRQ_FLAG, 8'h00);
		foreach (rows[r]) begin
			setup(rows[r].len, 1'b1, rows[r].auto_on, rows[r].mask);
			gap <= rows[r].gap;
			send(8'h00);
			rd(IDX_IRQ_FLAG, rows[r].mask);
			check(32'({irq, loop_active}), {23'h0, 1'b1, rows[r].active});
			rd(IDX_LOOP_STATUS, 8'hFF);
			rd(IDX_IRQ_FLAG, 8'h00);
			check(32'(irq), 32'h0);
			send(8'hFF);
			rd(IDX_IRQ_FLAG, rows[r].mask);
			rd(IDX_LOOP_STATUS, 8'h00);
			check(32'(loop_active), 32'h0);
		end
		// Lengths differ: eight-bit activation, five-bit deactivation
		setup(LEN_8, 1'b1, 1'b0, 8'hFF);
		send(8'h00);
		rd(IDX_LOOP_STATUS, 8'hFF);
		dcode <= rep(8'hE0, LEN_5);
		len_sel <= LEN_5;
		wr(IDX_DEACT_CODE, rep(8'hE0, LEN_5));
		wr(IDX_LOOP_CONFIG, 8'h00);
		wr(IDX_LOOP_CONFIG, {2'b00, 1'b1, 1'b0, LEN_8, LEN_5});
		send(8'hFF);
		rd(IDX_LOOP_STATUS, 8'h00);
		// Reset in mid-run drops status and mask
		setup(LEN_8, 1'b1, 1'b1, 8'hFF);
		send(8'h00);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(IDX_LOOP_STATUS, 8'h00);
		rd(IDX_IRQ_MASK, 8'h00);
		// Generators: one of each code, then disabled
		setup(LEN_7, 1'b0, 1'b0, 8'h00);
		wr(IDX_GEN_SELECT, 8'h02);
		wr(IDX_GEN_ENABLE, 8'h03);
		tx_run <= 1'b1;
		tx_check(8'h03, 8'h02, 14);
		tx_run <= 1'b0;
		wr(IDX_GEN_ENABLE, 8'h00);
		tx_run <= 1'b1;
		tx_check(8'h00, 8'h02, 4);
		results();
	end
endmodule

// ---- tb/line_far_end.sv ----
// Far-end line model: repeating loopback code bursts and
// transmit pacing. Shares the block's clock and reset.
`timescale 1ns/10ps
module line_far_end (
	input  wire logic			clock,
	input  wire logic			rst,
	input  wire logic			start,		// Begin a three-period burst
	input  wire logic [1:0]			len_sel,	// Code length field
	input  wire logic [7:0]			act_code,
	input  wire logic [7:0]			deact_code,
	input  wire logic [7:0]			use_deact,	// Per channel code choice
	input  wire logic [3:0]			gap,		// Cycles per bit: prompt or slow
	input  wire logic			tx_run,
	output logic				busy,
	output loopback_pkg::line_rx_t		line_rx,
	output loopback_pkg::line_tx_t		line_tx
);
	import loopback_pkg::*;
	// ==========
	// State
	logic [3:0]	wait_cnt;	// Cycles since last strobe
	logic [2:0]	bit_idx;	// Position in the code
	logic [1:0]	per_cnt;	// Whole periods sent
	logic [1:0]	tx_cnt;		// Transmit pacing
	logic [7:0]	cur_bits;	// Code bit for each channel
	logic		strobe;
	logic		last_bit;
	assign strobe = busy && wait_cnt == gap - 4'h1;
	assign last_bit = bit_idx == {1'b0, len_sel} + 3'h4;
	assign cur_bits = (use_deact & {8{deact_code[3'h7 - bit_idx]}}) | (~use_deact & {8{act_code[3'h7 - bit_idx]}});
	// ==========
	// Whole periods, MSB first; between strobes the data line
	// toggles so a stale bit never passes for a valid one
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			wait_cnt <= 4'h0;
			bit_idx <= 3'h0;
			per_cnt <= 2'h0;
			line_rx <= '0;
		end else begin
			line_rx.rx_valid <= strobe ? 8'hFF : 8'h00;
			line_rx.rx_bit <= strobe ? cur_bits : ~line_rx.rx_bit;
			wait_cnt <= (start || strobe) ? 4'h0 : wait_cnt + 4'h1;
			bit_idx <= (start || (strobe && last_bit)) ? 3'h0 : bit_idx + 3'(strobe);
			per_cnt <= start ? 2'h0 : per_cnt + 2'(strobe && last_bit);
			if (start)
				busy <= 1'b1;
			else if (strobe && last_bit && per_cnt == 2'h2)
				busy <= 1'b0;
		end
	end
	// ==========
	// Transmitters ask for a bit every fourth cycle while running
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_cnt <= 2'h0;
			line_tx <= {8'h00, 8'h5A};
		end else begin
			tx_cnt <= tx_run ? tx_cnt + 2'h1 : 2'h0;
			line_tx.tx_ready <= {8{tx_run && tx_cnt == 2'h3}};
			if (tx_run && tx_cnt == 2'h3)
				line_tx.tx_data <= line_tx.tx_data + 8'h37;
		end
	end
endmodule
